/* File: hw/ppm_pkg.sv */
// Constants and signal bundles of the pin multiplexer
package ppm_pkg;

   // =====================================================================
   // Sizes
   localparam int unsigned PIN_COUNT = 21;
   localparam int unsigned DIG_COUNT = 9;
   localparam int unsigned DIG_BASE  = 12;
   localparam int unsigned ADDR_W    = 5;
   localparam int unsigned REG_COUNT = 6;
   localparam int unsigned REG_SLOTS = 8;

   // =====================================================================
   // Register byte offsets
   localparam logic [4:0] OFS_PORT_DATA  = 5'h00;
   localparam logic [4:0] OFS_PORT_DIR   = 5'h04;
   localparam logic [4:0] OFS_PERIPH_EN  = 5'h08;
   localparam logic [4:0] OFS_PIN_SELECT = 5'h0C;
   localparam logic [4:0] OFS_PORT_LEVEL = 5'h10;
   localparam logic [4:0] OFS_ADC_REF    = 5'h14;

   // Values after reset: port function, all pins inputs
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Bit positions in the converter reference control register
   localparam int unsigned REF_A_HIGH = 0;
   localparam int unsigned REF_A_LOW  = 1;
   localparam int unsigned REF_B_HIGH = 2;
   localparam int unsigned REF_B_LOW  = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // =====================================================================
   // Pin positions in the pad vectors
   localparam int unsigned P_A0 = 0;
   localparam int unsigned P_A1 = 1;
   localparam int unsigned P_A2 = 2;
   localparam int unsigned P_A3 = 3;
   localparam int unsigned P_B0 = 4;
   // Digital pin slots in the select register
   localparam int unsigned D_C5  = 0;
   localparam int unsigned D_C6  = 1;
   localparam int unsigned D_C7  = 2;
   localparam int unsigned D_C8  = 3;
   localparam int unsigned D_C9  = 4;
   localparam int unsigned D_C10 = 5;
   localparam int unsigned D_F0  = 6;
   localparam int unsigned D_C11 = 7;
   localparam int unsigned D_C12 = 8;

   // =====================================================================
   // Signals from the peripherals towards the pads
   typedef struct packed {
      logic spi0_master;
      logic spi0_master_data_out;
      logic spi0_slave_data_out;
      logic spi0_serial_clock;
      logic spi1_master;
      logic spi1_serial_clock;
      logic sci0_transmit;
      logic sci0_single_wire;
      logic sci0_tx_active;
      logic sci1_transmit;
      logic sci1_single_wire;
      logic sci1_tx_active;
      logic timer_a2_out;
      logic timer_a2_drive;
      logic timer_b2_out;
      logic timer_b2_drive;
      logic can_transmit;
      logic iic_clock_low;
      logic iic_data_low;
      logic xbar_out6;
      logic xbar_out8;
      logic xbar_out9;
   } ppm_periph_out_s;

   // Signals from the pads towards the peripherals
   typedef struct packed {
      logic       spi0_slave_select_n;
      logic       spi0_mosi_in;
      logic       spi0_miso_in;
      logic       spi0_clock_in;
      logic       spi1_clock_in;
      logic       sci0_receive;
      logic       sci1_receive;
      logic       timer_a2_in;
      logic       timer_b2_in;
      logic       can_receive;
      logic       iic_clock_in;
      logic       iic_data_in;
      logic [9:3] xbar_in;
   } ppm_periph_in_s;

   // Analog switch enables
   typedef struct packed {
      logic [3:0] adc_a_channel;
      logic [7:0] adc_b_channel;
      logic       converter_a_high_reference;
      logic       converter_a_low_reference;
      logic       converter_b_high_reference;
      logic       converter_b_low_reference;
      logic [5:0] cmp_a_input;
      logic [5:0] cmp_b_input;
      logic [5:0] cmp_c_input;
      logic       cmp_d_input5;
      logic       dac_output;
   } ppm_analog_s;

endpackage

/* File: hw/ppm_pin_mux.sv */
// Port pin function multiplexer with AXI4-Lite control registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// =========================================================================
// Functional notes
// - Reset leaves every pin a port pin with no alternate function.
// - Each port bit has its own direction bit.
// - An analog pin feeds its comparator inputs and, unless set as a reference, its converter channel at once.
// - A control bit makes each of four pins a converter channel or a reference.
// - The spi0 slave data pad is released in slave mode while not selected.
// - The spi0 clock pin is an output in master mode and an input in slave mode.
// - The master data pin is an output in master mode and an input in slave mode.
// - The slave data pin receives data in master mode and drives data in slave mode.
// - In single-wire mode the serial transmit pin carries data both ways.
// - The shared comparator reference feeds input 5 of all four comparators.
// - Per-pin peripheral enables and function selects choose alternate functions.
module ppm_pin_mux #(
   parameter int unsigned PINS = ppm_pkg::PIN_COUNT
) (
   input  wire logic                     CLOCK_I,
   input  wire logic                     RST_I,
   input  wire logic [ppm_pkg::ADDR_W-1:0] AXI_AWADDR_I,
   input  wire logic                     AXI_AWVALID_I,
   output      logic                     AXI_AWREADY_O,
   input  wire logic [31:0]              AXI_WDATA_I,
   input  wire logic [3:0]               AXI_WSTRB_I,
   input  wire logic                     AXI_WVALID_I,
   output      logic                     AXI_WREADY_O,
   output      logic [1:0]               AXI_BRESP_O,
   output      logic                     AXI_BVALID_O,
   input  wire logic                     AXI_BREADY_I,
   input  wire logic [ppm_pkg::ADDR_W-1:0] AXI_ARADDR_I,
   input  wire logic                     AXI_ARVALID_I,
   output      logic                     AXI_ARREADY_O,
   output      logic [31:0]              AXI_RDATA_O,
   output      logic [1:0]               AXI_RRESP_O,
   output      logic                     AXI_RVALID_O,
   input  wire logic                     AXI_RREADY_I,
   input  wire logic [PINS-1:0]          PAD_IN_I,
   output      logic [PINS-1:0]          PAD_OUT_O,
   output      logic [PINS-1:0]          PAD_OE_N_O,
   input  wire ppm_pkg::ppm_periph_out_s PERIPH_I,
   output      ppm_pkg::ppm_periph_in_s  PERIPH_O,
   output      ppm_pkg::ppm_analog_s     ANALOG_O
);
   import ppm_pkg::*;

   // =====================================================================
   // Elaboration check
   generate
      if (PINS != PIN_COUNT) begin : g_bad_pins
         $error("PINS must equal the pin count of the group");
      end
   endgenerate

   // =====================================================================
   // Declarations
   logic [PINS-1:0]        data_reg;
   logic [PINS-1:0]        dir_reg;
   logic [PINS-1:0]        pe_reg;
   logic [2*DIG_COUNT-1:0] sel_reg;
   logic [3:0]             ref_reg;
   logic [PINS-1:0]        meta_reg;
   logic [PINS-1:0]        lvl_reg;
   logic [PINS-1:0]        pin_out_reg;
   logic [PINS-1:0]        pin_drv_reg;
   logic [PINS-1:0]        pin_out_next;
   logic [PINS-1:0]        pin_drv_next;
   logic [PINS-1:0]        alt_out;
   logic [PINS-1:0]        alt_drv;
   logic [3:0]             dsel [DIG_COUNT];

   logic [ADDR_W-1:0]      aw_addr_reg;
   logic                   aw_have_reg;
   logic [31:0]            w_data_reg;
   logic [3:0]             w_strb_reg;
   logic                   w_have_reg;
   logic                   bvalid_reg;
   logic [1:0]             bresp_reg;
   logic                   rvalid_reg;
   logic [31:0]            rdata_reg;
   logic [1:0]             rresp_reg;
   logic [31:0]            reg_word [REG_SLOTS];
   logic [2:0]             aw_idx;
   logic [2:0]             ar_idx;
   logic                   wr_go;
   logic                   wr_hit;
   logic                   ar_hit;
   logic [REG_COUNT-1:0]   wr_en;
   logic [31:0]            wr_word;

   logic                   ss_n;
   logic                   miso_drv;
   logic                   tx0_drv;
   logic                   tx1_drv;
   logic                   cref;
   logic [11:0]            ana;

   // Byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction

   // =====================================================================
   // AXI4-Lite slave
   assign aw_idx        = aw_addr_reg[4:2];
   assign ar_idx        = AXI_ARADDR_I[4:2];
   assign wr_go         = aw_have_reg & w_have_reg & ~bvalid_reg;
   assign wr_hit        = (32'(aw_idx) < REG_COUNT);
   assign ar_hit        = (32'(ar_idx) < REG_COUNT);
   assign wr_en         = (wr_go & wr_hit) ? (REG_COUNT'(1) << aw_idx) : '0;
   assign wr_word       = merge(reg_word[aw_idx], w_data_reg, w_strb_reg);
   assign AXI_AWREADY_O = ~aw_have_reg & ~bvalid_reg;
   assign AXI_WREADY_O  = ~w_have_reg & ~bvalid_reg;
   assign AXI_BVALID_O  = bvalid_reg;
   assign AXI_BRESP_O   = bresp_reg;
   assign AXI_ARREADY_O = ~rvalid_reg;
   assign AXI_RVALID_O  = rvalid_reg;
   assign AXI_RDATA_O   = rdata_reg;
   assign AXI_RRESP_O   = rresp_reg;

   assign reg_word[OFS_PORT_DATA[4:2]]  = 32'(data_reg);
   assign reg_word[OFS_PORT_DIR[4:2]]   = 32'(dir_reg);
   assign reg_word[OFS_PERIPH_EN[4:2]]  = 32'(pe_reg);
   assign reg_word[OFS_PIN_SELECT[4:2]] = 32'(sel_reg);
   assign reg_word[OFS_PORT_LEVEL[4:2]] = 32'(lvl_reg);
   assign reg_word[OFS_ADC_REF[4:2]]    = 32'(ref_reg);
   assign reg_word[6]                   = RST_WORD;
   assign reg_word[7]                   = RST_WORD;

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         aw_addr_reg <= '0;
         aw_have_reg <= 1'b0;
         w_data_reg  <= RST_WORD;
         w_strb_reg  <= '0;
         w_have_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end else begin
         if (AXI_AWVALID_I && AXI_AWREADY_O) begin
            aw_addr_reg <= AXI_AWADDR_I;
            aw_have_reg <= 1'b1;
         end
         if (AXI_WVALID_I && AXI_WREADY_O) begin
            w_data_reg <= AXI_WDATA_I;
            w_strb_reg <= AXI_WSTRB_I;
            w_have_reg <= 1'b1;
         end
         if (wr_go) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= RST_WORD;
         rresp_reg  <= RESP_OKAY;
      end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= ar_hit ? reg_word[ar_idx] : RST_WORD;
         rresp_reg  <= ar_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (AXI_RREADY_I) begin
         rvalid_reg <= 1'b0;
      end
   end

   // =====================================================================
   // Control registers
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         data_reg <= '0;
         dir_reg  <= '0;
         pe_reg   <= '0;
         sel_reg  <= '0;
         ref_reg  <= '0;
      end else begin
         if (wr_en[OFS_PORT_DATA[4:2]])  data_reg <= wr_word[PINS-1:0];
         if (wr_en[OFS_PORT_DIR[4:2]])   dir_reg  <= wr_word[PINS-1:0];
         if (wr_en[OFS_PERIPH_EN[4:2]])  pe_reg   <= wr_word[PINS-1:0];
         if (wr_en[OFS_PIN_SELECT[4:2]]) sel_reg  <= wr_word[2*DIG_COUNT-1:0];
         if (wr_en[OFS_ADC_REF[4:2]])    ref_reg  <= wr_word[3:0];
      end
   end

   // =====================================================================
   // Pad input synchroniser
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         meta_reg <= '0;
         lvl_reg  <= '0;
      end else begin
         meta_reg <= PAD_IN_I;
         lvl_reg  <= meta_reg;
      end
   end

   // =====================================================================
   // One-hot function decode per digital pin
   generate
      for (genvar d = 0; d < DIG_COUNT; d++) begin : g_dsel
         assign dsel[d] = pe_reg[DIG_BASE+d] ? (4'h1 << sel_reg[2*d +: 2]) : 4'h0;
      end
   endgenerate

   // =====================================================================
   // Alternate function pad drive
   assign ss_n     = dsel[D_C6][3] ? lvl_reg[DIG_BASE+D_C6]
                   : dsel[D_C7][0] ? lvl_reg[DIG_BASE+D_C7] : 1'b1;
   assign miso_drv = ~PERIPH_I.spi0_master & ~ss_n;
   assign tx0_drv  = ~PERIPH_I.sci0_single_wire | PERIPH_I.sci0_tx_active;
   assign tx1_drv  = ~PERIPH_I.sci1_single_wire | PERIPH_I.sci1_tx_active;

   // Analog pins drive digitally only as port pins
   assign alt_out[DIG_BASE-1:0] = '0;
   assign alt_drv[DIG_BASE-1:0] = '0;

   // Converter output and crossbar input only
   assign alt_out[DIG_BASE+D_C5] = 1'b0;
   assign alt_drv[DIG_BASE+D_C5] = 1'b0;

   assign alt_out[DIG_BASE+D_C6] = dsel[D_C6][0] & PERIPH_I.timer_a2_out;
   assign alt_drv[DIG_BASE+D_C6] = dsel[D_C6][0] & PERIPH_I.timer_a2_drive;

   assign alt_out[DIG_BASE+D_C7] = dsel[D_C7][1] & PERIPH_I.sci0_transmit;
   assign alt_drv[DIG_BASE+D_C7] = dsel[D_C7][1] & tx0_drv;

   assign alt_out[DIG_BASE+D_C8] = (dsel[D_C8][0] & PERIPH_I.spi0_slave_data_out)
                                 | (dsel[D_C8][3] & PERIPH_I.xbar_out6);
   assign alt_drv[DIG_BASE+D_C8] = (dsel[D_C8][0] & miso_drv) | dsel[D_C8][3];

   assign alt_out[DIG_BASE+D_C9] = (dsel[D_C9][0] & PERIPH_I.spi0_serial_clock)
                                 | (dsel[D_C9][2] & PERIPH_I.sci0_transmit)
                                 | (dsel[D_C9][3] & PERIPH_I.xbar_out8);
   assign alt_drv[DIG_BASE+D_C9] = (dsel[D_C9][0] & PERIPH_I.spi0_master)
                                 | (dsel[D_C9][2] & tx0_drv) | dsel[D_C9][3];

   assign alt_out[DIG_BASE+D_C10] = (dsel[D_C10][0] & PERIPH_I.spi0_master_data_out)
                                  | (dsel[D_C10][2] & PERIPH_I.spi0_slave_data_out)
                                  | (dsel[D_C10][3] & PERIPH_I.xbar_out9);
   assign alt_drv[DIG_BASE+D_C10] = (dsel[D_C10][0] & PERIPH_I.spi0_master)
                                  | (dsel[D_C10][2] & miso_drv) | dsel[D_C10][3];

   assign alt_out[DIG_BASE+D_F0] = (dsel[D_F0][1] & PERIPH_I.timer_b2_out)
                                 | (dsel[D_F0][2] & PERIPH_I.spi1_serial_clock);
   assign alt_drv[DIG_BASE+D_F0] = (dsel[D_F0][1] & PERIPH_I.timer_b2_drive)
                                 | (dsel[D_F0][2] & PERIPH_I.spi1_master);

   // IIC lines are open drain: drive low only; CAN and sci1 transmit on C11 drive both levels
   assign alt_out[DIG_BASE+D_C11] = (dsel[D_C11][0] & PERIPH_I.can_transmit)
                                  | (dsel[D_C11][2] & PERIPH_I.sci1_transmit);
   assign alt_drv[DIG_BASE+D_C11] = dsel[D_C11][0] | (dsel[D_C11][1] & PERIPH_I.iic_clock_low)
                                  | (dsel[D_C11][2] & tx1_drv);

   assign alt_out[DIG_BASE+D_C12] = 1'b0;
   assign alt_drv[DIG_BASE+D_C12] = dsel[D_C12][1] & PERIPH_I.iic_data_low;

   // =====================================================================
   // Pad output stage
   assign pin_out_next = (pe_reg & alt_out) | (~pe_reg & data_reg);
   assign pin_drv_next = (pe_reg & alt_drv) | (~pe_reg & dir_reg);
   assign PAD_OUT_O    = pin_out_reg;
   assign PAD_OE_N_O   = ~pin_drv_reg;

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         pin_out_reg <= '0;
         pin_drv_reg <= '0;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_drv_reg <= pin_drv_next;
      end
   end

   // =====================================================================
   // Pad levels to peripherals, idle when unselected
   assign PERIPH_O.spi0_slave_select_n = ss_n;
   assign PERIPH_O.spi0_mosi_in  = dsel[D_C10][0] & lvl_reg[DIG_BASE+D_C10];
   assign PERIPH_O.spi0_miso_in  = dsel[D_C8][0] ? lvl_reg[DIG_BASE+D_C8]
                                 : dsel[D_C10][2] & lvl_reg[DIG_BASE+D_C10];
   assign PERIPH_O.spi0_clock_in = dsel[D_C9][0] & lvl_reg[DIG_BASE+D_C9];
   assign PERIPH_O.spi1_clock_in = dsel[D_F0][2] & lvl_reg[DIG_BASE+D_F0];
   assign PERIPH_O.sci0_receive  = PERIPH_I.sci0_single_wire ?
                                   (dsel[D_C7][1] ? lvl_reg[DIG_BASE+D_C7]
                                   : dsel[D_C9][2] ? lvl_reg[DIG_BASE+D_C9] : 1'b1)
                                 : dsel[D_C8][1] ? lvl_reg[DIG_BASE+D_C8] : 1'b1;
   assign PERIPH_O.sci1_receive  = PERIPH_I.sci1_single_wire ?
                                   (dsel[D_C11][2] ? lvl_reg[DIG_BASE+D_C11] : 1'b1)
                                 : dsel[D_C12][2] ? lvl_reg[DIG_BASE+D_C12] : 1'b1;
   assign PERIPH_O.timer_a2_in   = dsel[D_C6][0] & lvl_reg[DIG_BASE+D_C6];
   assign PERIPH_O.timer_b2_in   = dsel[D_F0][1] & lvl_reg[DIG_BASE+D_F0];
   assign PERIPH_O.can_receive   = dsel[D_C12][0] ? lvl_reg[DIG_BASE+D_C12] : 1'b1;
   assign PERIPH_O.iic_clock_in  = dsel[D_C11][1] ? lvl_reg[DIG_BASE+D_C11] : 1'b1;
   assign PERIPH_O.iic_data_in   = dsel[D_C12][1] ? lvl_reg[DIG_BASE+D_C12] : 1'b1;
   assign PERIPH_O.xbar_in[3]    = dsel[D_C6][1] & lvl_reg[DIG_BASE+D_C6];
   assign PERIPH_O.xbar_in[4]    = dsel[D_C9][1] & lvl_reg[DIG_BASE+D_C9];
   assign PERIPH_O.xbar_in[5]    = dsel[D_C10][1] & lvl_reg[DIG_BASE+D_C10];
   assign PERIPH_O.xbar_in[6]    = dsel[D_F0][0] & lvl_reg[DIG_BASE+D_F0];
   assign PERIPH_O.xbar_in[7]    = dsel[D_C5][1] & lvl_reg[DIG_BASE+D_C5];
   assign PERIPH_O.xbar_in[8]    = dsel[D_C7][2] & lvl_reg[DIG_BASE+D_C7];
   assign PERIPH_O.xbar_in[9]    = dsel[D_C8][2] & lvl_reg[DIG_BASE+D_C8];

   // =====================================================================
   // Analog routing
   assign ana  = pe_reg[11:0];
   assign cref = dsel[D_C6][2];

   assign ANALOG_O.adc_a_channel[0] = ana[P_A0];
   assign ANALOG_O.adc_a_channel[1] = ana[P_A1];
   assign ANALOG_O.adc_a_channel[2] = ana[P_A2] & ~ref_reg[REF_A_HIGH];
   assign ANALOG_O.adc_a_channel[3] = ana[P_A3] & ~ref_reg[REF_A_LOW];
   assign ANALOG_O.converter_a_high_reference = ana[P_A2] & ref_reg[REF_A_HIGH];
   assign ANALOG_O.converter_a_low_reference  = ana[P_A3] & ref_reg[REF_A_LOW];
   assign ANALOG_O.adc_b_channel = ana[P_B0 +: 8]
                                 & ~{4'h0, ref_reg[REF_B_LOW], ref_reg[REF_B_HIGH], 2'h0};
   assign ANALOG_O.converter_b_high_reference = ana[P_B0+2] & ref_reg[REF_B_HIGH];
   assign ANALOG_O.converter_b_low_reference  = ana[P_B0+3] & ref_reg[REF_B_LOW];

   // Comparators keep the shared pins
   assign ANALOG_O.cmp_a_input = {cref, 1'b0, ana[P_A0], ana[P_A3], ana[P_A2], ana[P_A1]};
   assign ANALOG_O.cmp_b_input = {cref, 1'b0, ana[P_B0], ana[P_B0+7], ana[P_B0+6],
                                  ana[P_B0+1]};
   assign ANALOG_O.cmp_c_input = {cref, 1'b0, ana[P_B0+2], ana[P_B0+5], ana[P_B0+4],
                                  ana[P_B0+3]};
   assign ANALOG_O.cmp_d_input5 = cref;
   assign ANALOG_O.dac_output   = dsel[D_C5][0];

endmodule

/* File: bench/ppm_pin_mux_props.sv */
// Port assertions for the pin multiplexer
`timescale 1ns/1ps
// =====================================================================
// Checker
module ppm_pin_mux_props #(
   parameter int unsigned PINS = 21
) (
   input wire logic                 CLOCK_I,
   input wire logic                 RST_I,
   input wire logic                 AXI_AWVALID_I,
   input wire logic                 AXI_AWREADY_O,
   input wire logic                 AXI_WVALID_I,
   input wire logic                 AXI_WREADY_O,
   input wire logic                 AXI_BVALID_O,
   input wire logic                 AXI_BREADY_I,
   input wire logic [4:0]           AXI_ARADDR_I,
   input wire logic                 AXI_ARVALID_I,
   input wire logic                 AXI_ARREADY_O,
   input wire logic [31:0]          AXI_RDATA_O,
   input wire logic [1:0]           AXI_RRESP_O,
   input wire logic                 AXI_RVALID_O,
   input wire logic [PINS-1:0]      PAD_OUT_O,
   input wire logic [PINS-1:0]      PAD_OE_N_O,
   input wire ppm_pkg::ppm_analog_s ANALOG_O
);
   import ppm_pkg::*;
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   wr_answer_a: assert property (AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O |-> ##2 AXI_BVALID_O)
      else $error("write answer late");
   b_hold_a: assert property (AXI_BVALID_O && !AXI_BREADY_I |=> AXI_BVALID_O) else $error("bvalid dropped");
   rd_answer_a: assert property (AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O) else $error("read answer late");
   hole_read_a: assert property (AXI_ARVALID_I && AXI_ARREADY_O && AXI_ARADDR_I[4:3] == 2'h3
      |=> AXI_RRESP_O == RESP_SLVERR && AXI_RDATA_O == '0) else $error("bad hole read");
   reset_idle_a: assert property ($fell(RST_I) |-> &PAD_OE_N_O && PAD_OUT_O == '0) else $error("pads busy");
   analog_share_a: assert property (ANALOG_O.adc_a_channel[0] == ANALOG_O.cmp_a_input[3]
      && ANALOG_O.adc_b_channel[0] == ANALOG_O.cmp_b_input[3]) else $error("analog split");
   ref_choice_a: assert property (ANALOG_O.cmp_a_input[1] |->
      ANALOG_O.adc_a_channel[2] != ANALOG_O.converter_a_high_reference) else $error("ref clash");
   shared_comparator_reference_a: assert property (ANALOG_O.cmp_a_input[5] == ANALOG_O.cmp_b_input[5]
      && ANALOG_O.cmp_c_input[5] == ANALOG_O.cmp_d_input5 && ANALOG_O.cmp_a_input[5] == ANALOG_O.cmp_d_input5)
      else $error("ref split");
   cover property (AXI_BVALID_O && !AXI_BREADY_I);
   cover property (AXI_RVALID_O && AXI_RRESP_O == RESP_SLVERR);
   cover property (ANALOG_O.cmp_d_input5);
endmodule
bind ppm_pin_mux ppm_pin_mux_props #(.PINS(PINS)) u_props (.CLOCK_I, .RST_I, .AXI_AWVALID_I, .AXI_AWREADY_O,
   .AXI_WVALID_I, .AXI_WREADY_O, .AXI_BVALID_O, .AXI_BREADY_I, .AXI_ARADDR_I, .AXI_ARVALID_I, .AXI_ARREADY_O,
   .AXI_RDATA_O, .AXI_RRESP_O, .AXI_RVALID_O, .PAD_OUT_O, .PAD_OE_N_O, .ANALOG_O);

/* File: bench/ppm_board_model.sv */
// Board side of the pads: outside drivers and floating lines
`timescale 1ns/1ps
// =====================================================================
// Board model
module ppm_board_model #(
   parameter int unsigned W = 21
) (
   input  wire logic         clk_i,
   input  wire logic [W-1:0] pad_out_i,
   input  wire logic [W-1:0] pad_oe_n_i,
   input  wire logic [W-1:0] ext_val_i,
   input  wire logic [W-1:0] ext_en_i,
   output      logic [W-1:0] pad_lvl_o
);
   logic flip_reg = 1'b0;
   always_ff @(posedge clk_i) flip_reg <= ~flip_reg;
   // Device wins where it drives; an unheld line wanders every cycle
   assign pad_lvl_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ext_en_i & ext_val_i)
      | (pad_oe_n_i & ~ext_en_i & {W{flip_reg}});
endmodule

/* File: bench/test_port_pin_function_mux.sv */
// Self-checking bench for the port pin multiplexer
`timescale 1ns/1ps
// =====================================================================
// Bench
module test_port_pin_function_mux;
   import ppm_pkg::*;
   logic clk = 0, rst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, awr, wrdy, bv, arr, rv;
   logic [4:0] awa = '0, ara = '0;
   logic [3:0] strb = '1;
   logic [31:0] wd = '0, rdat;
   logic [1:0] bresp, rresp;
   logic [20:0] pin, pout, poe_n, ext = '0, ext_en = '1;
   ppm_periph_out_s po = '0;
   ppm_periph_in_s pi;
   ppm_analog_s an;
   int miscompares = 0, cmp_count = 0;
   ppm_pin_mux u_dut (.CLOCK_I(clk), .RST_I(rst), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr),
      .AXI_WDATA_I(wd), .AXI_WSTRB_I(strb), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrdy), .AXI_BRESP_O(bresp),
      .AXI_BVALID_O(bv), .AXI_BREADY_I(brdy), .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr),
      .AXI_RDATA_O(rdat), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rv), .AXI_RREADY_I(rrdy), .PAD_IN_I(pin),
      .PAD_OUT_O(pout), .PAD_OE_N_O(poe_n), .PERIPH_I(po), .PERIPH_O(pi), .ANALOG_O(an));
   ppm_board_model u_board (.clk_i(clk), .pad_out_i(pout), .pad_oe_n_i(poe_n), .ext_val_i(ext), .ext_en_i(ext_en),
      .pad_lvl_o(pin));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         miscompares++;
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      awa <= a; wd <= d; strb <= s; awv <= 1; wv <= 1; brdy <= 1;
      for (n = 0; n < 30; n++) begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
         if (bv) break;
      end
      if (n == 30) begin chk("handshake", 1, 0); test_done(); end
      chk("bresp", er, bresp);
      brdy <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      ara <= a; arv <= 1; rrdy <= 1;
      for (n = 0; n < 30; n++) begin
         @(posedge clk);
         if (arr) arv <= 0;
         if (rv) break;
      end
      if (n == 30) begin chk("handshake", 1, 0); test_done(); end
      chk("rdata", e, rdat);
      chk("rresp", er, rresp);
      rrdy <= 0;
      @(posedge clk);
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask
   task automatic t_reset;
      int i;
      chk("oe_n", 32'h001F_FFFF, poe_n);
      chk("analog", 0, 32'(|an));
      chk("select_n", 1, pi.spi0_slave_select_n);
      for (i = 0; i < 6; i++) rd(5'(i * 4), 0, RESP_OKAY);
      rd(5'h18, 0, RESP_SLVERR);
      wr(5'h1C, '1, 4'hF, RESP_SLVERR);
      $display("test reset done");
   endtask
   task automatic t_port;
      wr(OFS_PORT_DIR, 32'h0000_0010, 4'hF, RESP_OKAY);
      wr(OFS_PORT_DATA, '1, 4'h1, RESP_OKAY);
      rd(OFS_PORT_DATA, 32'h0000_00FF, RESP_OKAY);
      chk("oe_n", 32'h001F_FFEF, poe_n);
      chk("pad_out", 1, pout[4]);
      rd(OFS_PORT_LEVEL, 32'h0000_0010, RESP_OKAY);
      $display("test port done");
   endtask
   task automatic t_analog;
      wr(OFS_PORT_DIR, '1, 4'hF, RESP_OKAY);
      wr(OFS_PERIPH_EN, 32'h0000_200F, 4'hF, RESP_OKAY);
      wr(OFS_PIN_SELECT, 32'h0000_0008, 4'hF, RESP_OKAY);
      chk("oe_n", 32'h0000_000F, poe_n[3:0]);
      chk("adc_a", 32'h0000_000F, an.adc_a_channel);
      chk("cmp_a", 32'h0000_000F, an.cmp_a_input[3:0]);
      chk("shared_comparator_reference", 32'h0000_000F, {an.cmp_a_input[5], an.cmp_b_input[5], an.cmp_c_input[5], an.cmp_d_input5});
      wr(OFS_ADC_REF, 32'h0000_0001, 4'hF, RESP_OKAY);
      chk("adc_a", 32'h0000_000B, an.adc_a_channel);
      chk("ref_high", 1, an.converter_a_high_reference);
      $display("test analog done");
   endtask
   task automatic t_spi;
      wr(OFS_PERIPH_EN, 32'h0003_C000, 4'hF, RESP_OKAY);
      po.spi0_master <= 1; po.spi0_serial_clock <= 1; po.spi0_master_data_out <= 1; po.spi0_slave_data_out <= 1;
      ext <= 21'h00_8000;
      settle();
      chk("oe_n", 32'h0000_0003, poe_n[17:14]);
      chk("pad_out", 32'h0000_0003, pout[17:16]);
      chk("miso_in", 1, pi.spi0_miso_in);
      po.spi0_master <= 0;
      ext <= 21'h03_4000;
      settle();
      chk("oe_n", 32'h0000_000F, poe_n[17:14]);
      chk("clock_in", 1, pi.spi0_clock_in);
      chk("mosi_in", 1, pi.spi0_mosi_in);
      ext <= 21'h00_0000;
      settle();
      chk("oe_n", 32'h0000_000D, poe_n[17:14]);
      chk("miso_out", 1, pout[15]);
      $display("test spi done");
   endtask
   task automatic t_wire;
      wr(OFS_PERIPH_EN, 32'h0008_0000, 4'hF, RESP_OKAY);
      wr(OFS_PIN_SELECT, 32'h0000_8000, 4'hF, RESP_OKAY);
      po.sci1_single_wire <= 1; po.sci1_transmit <= 0; ext <= 21'h08_0000;
      settle();
      chk("oe_n", 1, poe_n[19]);
      chk("receive", 1, pi.sci1_receive);
      po.sci1_tx_active <= 1;
      settle();
      chk("oe_n", 0, poe_n[19]);
      chk("transmit", 0, pout[19]);
      $display("test single wire done");
   endtask
   initial forever #4 clk = ~clk;
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      t_reset();
      t_port();
      t_analog();
      t_spi();
      t_wire();
      test_done();
   end
endmodule
